/* tb/device_config_latches_asserts.sv */
module device_config_latches_asserts
	import device_config_latches_pkg::*;
#(
	parameter int unsigned PINS_PER_PORT = 8
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic rd_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire logic [NUM_PORTS*DRIVE_MODE_W-1:0] port_reset_drive_mode_o,
	input wire logic [NUM_PORTS*PINS_PER_PORT*DRIVE_MODE_W-1:0]
		pin_reset_drive_mode_o,
	input wire logic reset_pin_select_o,
	input wire logic shared_pin_gpio_o,
	input wire logic boot_clock_speed_o,
	input wire logic [5:0] boot_clock_mhz_o,
	input wire logic [1:0] debug_port_select_o,
	input wire logic jtag5_en_o,
	input wire logic jtag4_en_o,
	input wire logic swd_en_o,
	input wire logic debug_off_o,
	input wire logic correction_region_enable_o,
	input wire logic [PHASE_W-1:0] digital_clock_phase_delay_o,
	input wire logic config_applied_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [NUM_PORTS*PINS_PER_PORT*DRIVE_MODE_W-1:0] pins_exp;
	always_comb begin
		for (int i = 0; i < NUM_PORTS*PINS_PER_PORT; i++) begin
			pins_exp[2*i+:2] =
				port_reset_drive_mode_o[2*(i/PINS_PER_PORT)+:2];
		end
	end
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence release_seen;
		$rose(rst_n_i);
	endsequence
	sequence read_then_idle;
		rd_i ##1 !rd_i;
	endsequence
	chk_gpio_inverse: assert property (shared_pin_gpio_o == !reset_pin_select_o)
		else $error("gpio flag not inverse of reset pin select");
	chk_boot_rate: assert property (
		boot_clock_mhz_o == (boot_clock_speed_o ?
		BOOT_CLK_FAST_MHZ : BOOT_CLK_SLOW_MHZ))
		else $error("boot clock rate does not follow speed bit");
	chk_debug_decode: assert property ({debug_off_o, swd_en_o, jtag4_en_o,
		jtag5_en_o} == 4'h1 << debug_port_select_o)
		else $error("debug enables do not decode the select");
	chk_pin_copy: assert property (pin_reset_drive_mode_o == pins_exp)
		else $error("pin drive mode differs from its port");
	chk_capture_once: assert property (release_seen |->
		!config_applied_o ##1 config_applied_o)
		else $error("capture not on first edge after release");
	chk_hold_stable: assert property (config_applied_o |=>
		config_applied_o && $stable(port_reset_drive_mode_o) &&
		$stable(debug_port_select_o) && $stable(boot_clock_speed_o) &&
		$stable(correction_region_enable_o) &&
		$stable(digital_clock_phase_delay_o) && $stable(reset_pin_select_o))
		else $error("working configuration changed before reset");
	chk_read_idle: assert property (read_then_idle |=> rdata_o == 8'h00)
		else $error("read data not cleared after its cycle");
	chk_byte3_copy: assert property (config_applied_o && rd_i &&
		addr_i == 4'h7 |=> rdata_o == {digital_clock_phase_delay_o,
		correction_region_enable_o, debug_port_select_o, boot_clock_speed_o})
		else $error("applied byte 3 layout wrong");
	chk_hole_zero: assert property (rd_i && addr_i > 4'h8 |=>
		rdata_o == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind device_config_latches device_config_latches_asserts #(
	.PINS_PER_PORT(PINS_PER_PORT)
) i_device_config_latches_asserts (.sys_clk_i, .rst_n_i, .addr_i, .rd_i,
	.rdata_o, .port_reset_drive_mode_o, .pin_reset_drive_mode_o,
	.reset_pin_select_o, .shared_pin_gpio_o, .boot_clock_speed_o,
	.boot_clock_mhz_o, .debug_port_select_o, .jtag5_en_o, .jtag4_en_o,
	.swd_en_o, .debug_off_o, .correction_region_enable_o,
	.digital_clock_phase_delay_o, .config_applied_o);

/* tb/test_device_config_latches.sv */
module test_device_config_latches;
	timeunit 1ns;
	timeprecision 1ns;
	import device_config_latches_pkg::*;
	logic sys_clk_i = 1'b0, rst_n_i = 1'b0, por_n_i = 1'b0;
	logic [ADDR_W-1:0] addr_i = 4'h0;
	logic [DATA_W-1:0] wdata_i = 8'h00, rdata_o;
	logic wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
	logic [17:0] port_reset_drive_mode_o;
	logic reset_pin_select_o, shared_pin_gpio_o, boot_clock_speed_o;
	logic [5:0] boot_clock_mhz_o;
	logic [1:0] debug_port_select_o;
	logic jtag5_en_o, jtag4_en_o, swd_en_o, debug_off_o;
	logic correction_region_enable_o, config_applied_o;
	logic [3:0] digital_clock_phase_delay_o;
	logic [38:0] cfg_q[$];
	logic [7:0] rd_q[$];
	logic [7:0] b[4];
	logic [31:0] lfsr = 32'hCD27B580;
	int bad_count = 0, samples_checked = 0;
	wire [38:0] cfg_now = {port_reset_drive_mode_o, reset_pin_select_o,
		shared_pin_gpio_o, boot_clock_speed_o, boot_clock_mhz_o,
		debug_port_select_o, debug_off_o, swd_en_o, jtag4_en_o, jtag5_en_o,
		correction_region_enable_o, digital_clock_phase_delay_o,
		config_applied_o};
	device_config_latches i_device_config_latches (.sys_clk_i, .rst_n_i,
		.por_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.port_reset_drive_mode_o, .pin_reset_drive_mode_o(),
		.reset_pin_select_o, .shared_pin_gpio_o, .boot_clock_speed_o,
		.boot_clock_mhz_o, .debug_port_select_o, .jtag5_en_o, .jtag4_en_o,
		.swd_en_o, .debug_off_o, .correction_region_enable_o,
		.digital_clock_phase_delay_o, .config_applied_o);
	function automatic logic [38:0] cfg_of(input logic [7:0] b0, b1, b2, b3);
		return {b2[1:0], b1, b0, b2[7], ~b2[7], b3[0],
			b3[0] ? BOOT_CLK_FAST_MHZ : BOOT_CLK_SLOW_MHZ, b3[2:1],
			4'h1 << b3[2:1], b3[3], b3[7:4], 1'b1};
	endfunction
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
	endfunction
	task automatic cmp_cfg(input logic [38:0] got, input logic [38:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		rd_q.push_back(e);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
	endtask
	// Defaults checked mid-reset, capture checked on the first edge after
	task automatic reset_cycle(input logic [38:0] e);
		@(posedge sys_clk_i);
		rst_n_i <= 1'b0;
		cfg_q.push_back(cfg_of(8'h00, 8'h00, 8'h00, 8'h02) & ~39'h1);
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		por_n_i <= 1'b1;
		@(posedge sys_clk_i);
		cfg_q.push_back(e);
	endtask
	task automatic give_verdict();
		$display("checked %0d, mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial forever #10 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) rd_d <= rd_i;
	always @(negedge sys_clk_i) begin
		if (rd_d) cmp_byte(rdata_o, rd_q.pop_front());
		if (cfg_q.size() > 0) cmp_cfg(cfg_now, cfg_q.pop_front());
	end
	initial begin
		repeat (5000) @(posedge sys_clk_i);
		bad_count++;
		give_verdict();
	end
	initial begin
		logic [38:0] e;
		reset_cycle(cfg_of(8'h00, 8'h00, 8'h00, 8'h02));
		for (int i = 0; i < 4; i++) rd(4'(i), i == 3 ? 8'h02 : 8'h00);
		wr(4'h4, 8'hFF);
		rd(4'h4, 8'h00);
		rd(4'hC, 8'h00);
		rd(4'h8, 8'h01);
		$display("test factory done");
		for (int n = 0; n < 4; n++) begin
			for (int i = 0; i < 4; i++) begin
				lfsr = step(lfsr);
				b[i] = lfsr[7:0] ^ lfsr[23:16];
			end
			// First pass sets all four drive codes
			if (n == 0) b[0] = 8'hE4;
			b[2][7] = n[0];
			b[3][0] = n[1];
			b[3][2:1] = n[1:0];
			// One rewrite of each latch byte before the pass's reset
			for (int i = 0; i < 4; i++) wr(4'(i), b[i]);
			for (int i = 0; i < 4; i++) begin
				rd(4'(i), b[i] & (i == 2 ? 8'h83 : 8'hFF));
			end
			e = cfg_of(b[0], b[1], b[2], b[3]);
			reset_cycle(e);
			wr(4'h3, ~b[3]);
			cfg_q.push_back(e);
			rd(4'h7, b[3]);
			rd(4'h3, ~b[3]);
			rd(4'h8, 8'h03);
			$display("test pass %0d done", n);
		end
		repeat (2) @(posedge sys_clk_i);
		give_verdict();
	end
endmodule

/* verilog/device_config_latches.sv */
// Overview of operation
// - Four bytes of nonvolatile latches set the configuration out of reset.
// - Two-bit port field: analog hiZ, digital hiZ, pull-up, pull-down.
// - A port's drive mode applies identically to all its pins during reset.
// - Reset pin select: 0 general I/O, 1 external reset input.
// - Boot clock speed: 0 gives 12 MHz, 1 gives 48 MHz.
// - Debug select: 5-wire JTAG, 4-wire JTAG, serial wire, or disabled.
// - Correction enable: 0 spare flash holds data, 1 holds correction bytes.
// - Four-bit digital clock phase delay passes to clock distribution.
// - Byte 3: speed bit 0, debug bits 2:1, correction 3, phase 7:4.
module device_config_latches
	import device_config_latches_pkg::*;
#(
	parameter int unsigned PINS_PER_PORT = 8,
	parameter logic RESET_PIN_DEFAULT = 1'b0,
	parameter logic [3:0] PHASE_DELAY_DEFAULT = 4'h0
) (
	// Clock and resets
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic por_n_i,
	// Register port
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [DATA_W-1:0] rdata_o,
	// Port reset drive modes
	output logic [NUM_PORTS*DRIVE_MODE_W-1:0] port_reset_drive_mode_o,
	output logic [NUM_PORTS*PINS_PER_PORT*DRIVE_MODE_W-1:0]
		pin_reset_drive_mode_o,
	// Shared pin use
	output logic reset_pin_select_o,
	output logic shared_pin_gpio_o,
	// Boot clock
	output logic boot_clock_speed_o,
	output logic [5:0] boot_clock_mhz_o,
	// Debug port
	output logic [1:0] debug_port_select_o,
	output logic jtag5_en_o,
	output logic jtag4_en_o,
	output logic swd_en_o,
	output logic debug_off_o,
	// Flash spare region and clock phase
	output logic correction_region_enable_o,
	output logic [PHASE_W-1:0] digital_clock_phase_delay_o,
	// Status
	output logic config_applied_o
);

	timeunit 1ns;
	timeprecision 1ns;

	// Widths of the packed drive mode outputs
	localparam int unsigned PORT_BITS = NUM_PORTS * DRIVE_MODE_W;
	localparam int unsigned PIN_BITS = PORT_BITS * PINS_PER_PORT;
	// Factory bytes with the parameter defaults merged in
	localparam logic [7:0] LATCH2_DEF =
		LATCH2_RST | ({7'h00, RESET_PIN_DEFAULT} << RESET_PIN_BIT);
	localparam logic [7:0] LATCH3_DEF =
		(LATCH3_RST & 8'h0F) | {PHASE_DELAY_DEFAULT, 4'h0};
	localparam logic [1:0] DEBUG_DEF = LATCH3_DEF[DEBUG_SEL_LSB +: 2];

	// Nonvolatile image and the copy in force
	logic [7:0] config_latch_reg [LATCH_BYTES];
	logic [7:0] applied_reg [LATCH_BYTES];
	load_state_e state_reg;
	load_state_e state_next;
	logic capture;
	logic pending;
	logic [DATA_W-1:0] rdata_next;

	// Implemented bits of a latch byte
	function automatic logic [7:0] byte_mask(input logic [1:0] idx);
		case (idx)
			2'h0: byte_mask = LATCH0_MASK;
			2'h1: byte_mask = LATCH1_MASK;
			2'h2: byte_mask = LATCH2_MASK;
			default: byte_mask = LATCH3_MASK;
		endcase
	endfunction

	// Factory value of a latch byte
	function automatic logic [7:0] byte_default(input logic [1:0] idx);
		case (idx)
			2'h0: byte_default = LATCH0_RST;
			2'h1: byte_default = LATCH1_RST;
			2'h2: byte_default = LATCH2_DEF;
			default: byte_default = LATCH3_DEF;
		endcase
	endfunction

	// Port fields packed: byte 2 low bits over bytes 1 and 0
	function automatic logic [PORT_BITS-1:0] port_modes(
		input logic [7:0] b0,
		input logic [7:0] b1,
		input logic [7:0] b2
	);
		port_modes = {b2[DRIVE_MODE_W-1:0], b1, b0};
	endfunction

	// One port mode fanned out to every pin of that port
	function automatic logic [PIN_BITS-1:0] pin_modes(
		input logic [PORT_BITS-1:0] ports
	);
		logic [PIN_BITS-1:0] res;
		res = '0;
		for (int p = 0; p < NUM_PORTS; p++) begin
			for (int k = 0; k < PINS_PER_PORT; k++) begin
				res[(p*PINS_PER_PORT+k)*DRIVE_MODE_W +: DRIVE_MODE_W] =
					ports[p*DRIVE_MODE_W +: DRIVE_MODE_W];
			end
		end
		pin_modes = res;
	endfunction

	// Debug select field of byte 3
	function automatic logic [1:0] dbg_field(input logic [7:0] b3);
		dbg_field = b3[DEBUG_SEL_LSB +: 2];
	endfunction

	// Phase delay field of byte 3
	function automatic logic [PHASE_W-1:0] phase_field(input logic [7:0] b3);
		phase_field = b3[PHASE_LSB +: PHASE_W];
	endfunction

	// Boot clock rate in MHz for a speed bit
	function automatic logic [5:0] boot_mhz(input logic fast);
		boot_mhz = fast ? BOOT_CLK_FAST_MHZ : BOOT_CLK_SLOW_MHZ;
	endfunction

	// Load sequence: one capture cycle after reset release
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_LOAD: state_next = ST_RUN;
			ST_RUN: state_next = ST_RUN;
			default: state_next = ST_LOAD;
		endcase
	end

	// High for the single capture cycle after release
	assign capture = (state_reg == ST_LOAD);

	// Re-armed by every device reset
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_LOAD;
		end else begin
			state_reg <= state_next;
		end
	end

	// Latch array: loaded with factory bytes only at power-on, survives device reset
	always_ff @(posedge sys_clk_i or negedge por_n_i) begin
		if (!por_n_i) begin
			for (int i = 0; i < LATCH_BYTES; i++) begin
				config_latch_reg[i] <= byte_default(2'(i));
			end
		end else if (wr_i && addr_i < APPLIED_BASE_OFS) begin
			// Offsets 4 and up are read-only
			// Reserved bits of byte 2 are masked off on the way in
			// Each write wears the cell; no rate limit enforced here
			config_latch_reg[addr_i[1:0]] <=
				wdata_i & byte_mask(addr_i[1:0]);
		end
	end

	// Working copy taken once per reset, then frozen
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < LATCH_BYTES; i++) begin
				applied_reg[i] <= byte_default(2'(i));
			end
		end else if (capture) begin
			for (int i = 0; i < LATCH_BYTES; i++) begin
				applied_reg[i] <= config_latch_reg[i];
			end
		end
	end

	// Port drive modes
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port_reset_drive_mode_o <= port_modes(LATCH0_RST, LATCH1_RST,
				LATCH2_DEF);
			pin_reset_drive_mode_o <= pin_modes(port_modes(LATCH0_RST,
				LATCH1_RST, LATCH2_DEF));
		end else if (capture) begin
			port_reset_drive_mode_o <= port_modes(config_latch_reg[0],
				config_latch_reg[1], config_latch_reg[2]);
			// Pins copy their port field, so no pin can differ
			pin_reset_drive_mode_o <= pin_modes(port_modes(
				config_latch_reg[0], config_latch_reg[1],
				config_latch_reg[2]));
		end
	end

	// Shared reset / general I/O pin
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			reset_pin_select_o <= RESET_PIN_DEFAULT;
			shared_pin_gpio_o <= !RESET_PIN_DEFAULT;
		end else if (capture) begin
			reset_pin_select_o <= config_latch_reg[2][RESET_PIN_BIT];
			shared_pin_gpio_o <= !config_latch_reg[2][RESET_PIN_BIT];
		end
	end

	// Boot clock speed
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			boot_clock_speed_o <= LATCH3_RST[BOOT_SPEED_BIT];
			boot_clock_mhz_o <= boot_mhz(LATCH3_RST[BOOT_SPEED_BIT]);
		end else if (capture) begin
			boot_clock_speed_o <= config_latch_reg[3][BOOT_SPEED_BIT];
			boot_clock_mhz_o <=
				boot_mhz(config_latch_reg[3][BOOT_SPEED_BIT]);
		end
	end

	// Debug port selection and one-hot enables
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			debug_port_select_o <= DEBUG_DEF;
			jtag5_en_o <= (DEBUG_DEF == DBG_JTAG5);
			jtag4_en_o <= (DEBUG_DEF == DBG_JTAG4);
			swd_en_o <= (DEBUG_DEF == DBG_SWD);
			debug_off_o <= (DEBUG_DEF == DBG_OFF);
		end else if (capture) begin
			// Decoded once here so the enables stay one-hot flops
			debug_port_select_o <= dbg_field(config_latch_reg[3]);
			jtag5_en_o <= dbg_field(config_latch_reg[3]) == DBG_JTAG5;
			jtag4_en_o <= dbg_field(config_latch_reg[3]) == DBG_JTAG4;
			swd_en_o <= dbg_field(config_latch_reg[3]) == DBG_SWD;
			debug_off_o <= dbg_field(config_latch_reg[3]) == DBG_OFF;
		end
	end

	// Spare flash use and clock phase delay
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			correction_region_enable_o <= LATCH3_RST[CORR_EN_BIT];
			digital_clock_phase_delay_o <= PHASE_DELAY_DEFAULT;
		end else if (capture) begin
			correction_region_enable_o <=
				config_latch_reg[3][CORR_EN_BIT];
			digital_clock_phase_delay_o <=
				phase_field(config_latch_reg[3]);
		end
	end

	// Applied flag rises on the capture edge itself
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			config_applied_o <= 1'b0;
		end else begin
			config_applied_o <= (state_next == ST_RUN);
		end
	end

	// Latch contents differ from the configuration in force
	always_comb begin
		pending = 1'b0;
		for (int i = 0; i < LATCH_BYTES; i++) begin
			if (config_latch_reg[i] != applied_reg[i]) begin
				pending = 1'b1;
			end
		end
	end

	// Read decode; unmapped offsets read zero
	always_comb begin
		rdata_next = '0;
		case (addr_i)
			PORT_RESET_DRIVE_LOW_OFS,
			PORT_RESET_DRIVE_HIGH_OFS,
			RESET_PIN_AND_PORT_CFG_OFS,
			BOOT_AND_DEBUG_CFG_OFS: begin
				rdata_next = config_latch_reg[addr_i[1:0]];
			end
			CONFIG_STATUS_OFS: begin
				rdata_next[STATUS_APPLIED_BIT] = config_applied_o;
				rdata_next[STATUS_PENDING_BIT] = pending;
			end
			default: begin
				// Applied copies sit four bytes above the latches
				if (addr_i >= APPLIED_BASE_OFS &&
					addr_i <= APPLIED_LAST_OFS) begin
					rdata_next = applied_reg[addr_i[1:0]];
				end
			end
		endcase
	end

	// Read data valid for exactly the cycle after the strobe
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			rdata_o <= rdata_next;
		end else begin
			rdata_o <= '0;
		end
	end

endmodule

/* verilog/device_config_latches_pkg.sv */
package device_config_latches_pkg;

	// Register bus geometry
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned LATCH_BYTES = 4;

	// Latch array offsets
	localparam logic [3:0] PORT_RESET_DRIVE_LOW_OFS = 4'h0;
	localparam logic [3:0] PORT_RESET_DRIVE_HIGH_OFS = 4'h1;
	localparam logic [3:0] RESET_PIN_AND_PORT_CFG_OFS = 4'h2;
	localparam logic [3:0] BOOT_AND_DEBUG_CFG_OFS = 4'h3;
	// Read-only copies of the configuration in force
	localparam logic [3:0] APPLIED_BASE_OFS = 4'h4;
	localparam logic [3:0] APPLIED_LAST_OFS = 4'h7;
	// Status: bit 0 applied, bit 1 pending
	localparam logic [3:0] CONFIG_STATUS_OFS = 4'h8;
	localparam int unsigned STATUS_APPLIED_BIT = 0;
	localparam int unsigned STATUS_PENDING_BIT = 1;

	// Field positions
	localparam int unsigned DRIVE_MODE_W = 2;
	localparam int unsigned NUM_PORTS = 9;
	localparam int unsigned RESET_PIN_BIT = 7;
	localparam int unsigned BOOT_SPEED_BIT = 0;
	localparam int unsigned DEBUG_SEL_LSB = 1;
	localparam int unsigned CORR_EN_BIT = 3;
	localparam int unsigned PHASE_LSB = 4;
	localparam int unsigned PHASE_W = 4;

	// Implemented bits of each latch byte
	localparam logic [7:0] LATCH0_MASK = 8'hFF;
	localparam logic [7:0] LATCH1_MASK = 8'hFF;
	localparam logic [7:0] LATCH2_MASK = 8'h83;
	localparam logic [7:0] LATCH3_MASK = 8'hFF;

	// Factory contents
	localparam logic [7:0] LATCH0_RST = 8'h00;
	localparam logic [7:0] LATCH1_RST = 8'h00;
	localparam logic [7:0] LATCH2_RST = 8'h00;
	localparam logic [7:0] LATCH3_RST = 8'h02;

	// Boot clock rates
	localparam logic [5:0] BOOT_CLK_SLOW_MHZ = 6'h0C;
	localparam logic [5:0] BOOT_CLK_FAST_MHZ = 6'h30;

	typedef enum logic [1:0] {
		DRIVE_HIZ_ANALOG = 2'h0,
		DRIVE_HIZ_DIGITAL = 2'h1,
		DRIVE_PULL_UP = 2'h2,
		DRIVE_PULL_DOWN = 2'h3
	} drive_mode_e;

	typedef enum logic [1:0] {
		DBG_JTAG5 = 2'h0,
		DBG_JTAG4 = 2'h1,
		DBG_SWD = 2'h2,
		DBG_OFF = 2'h3
	} debug_port_e;

	typedef enum logic {
		ST_LOAD = 1'b0,
		ST_RUN = 1'b1
	} load_state_e;

endpackage
